// ===== src/cow0_pkg.sv
// Constants and types for the charger option word zero register bank.
// Assumes a byte-wide register port decoded elsewhere into offset, strobes and data.
package cow0_pkg;
  localparam logic [7:0]  COW0_OFS_LO       = 8'h00;
  localparam logic [7:0]  COW0_OFS_HI       = 8'h01;
  localparam logic [15:0] COW0_RESET        = 16'hE70E;
  localparam int          COW0_BIT_LOWPWR   = 15;
  localparam int          COW0_BIT_WDT_HI   = 14;
  localparam int          COW0_BIT_WDT_LO   = 13;
  localparam int          COW0_BIT_AUTOOFF  = 12;
  localparam int          COW0_BIT_REVGOOD  = 11;
  localparam int          COW0_BIT_AUDIBLE  = 10;
  localparam int          COW0_BIT_RATE     = 9;
  localparam int          COW0_BIT_STRONG   = 8;
  localparam int          COW0_BIT_LOOPEN   = 1;
  localparam logic [1:0]  COW0_WDT_OFF      = 2'h0;
  localparam logic [1:0]  COW0_WDT_5S       = 2'h1;
  localparam logic [1:0]  COW0_WDT_88S      = 2'h2;
  localparam longint      COW0_CLK_HZ       = 20000000;
  localparam longint      COW0_WDT_A_SEC    = 5;
  localparam longint      COW0_WDT_B_SEC    = 88;
  localparam longint      COW0_WDT_C_SEC    = 175;
  localparam longint      COW0_WDT_A_CYC    = COW0_WDT_A_SEC * COW0_CLK_HZ;
  localparam longint      COW0_WDT_B_CYC    = COW0_WDT_B_SEC * COW0_CLK_HZ;
  localparam longint      COW0_WDT_C_CYC    = COW0_WDT_C_SEC * COW0_CLK_HZ;

  typedef struct packed {
    logic       regulator_on;
    logic       hot_alert_on;
    logic       monitor_buf_on;
    logic       comparator_on;
    logic       adc_avail;
  } cow0_power_s;

  typedef struct packed {
    logic       rate_800k;
    logic       audible_clamp;
    logic       strong_drive_on;
  } cow0_switch_s;
endpackage

// ===== src/cow0_regbank.sv
// Register bank for charger option word zero with watchdog and loop auto-off.
// Assumes a decoded byte register port and synchronous pin inputs on i_clk_sys.
`timescale 1ns/100ps
module cow0_regbank
  import cow0_pkg::*;
#(
  parameter longint WDT_A_CYC = COW0_WDT_A_CYC,
  parameter longint WDT_B_CYC = COW0_WDT_B_CYC,
  parameter longint WDT_C_CYC = COW0_WDT_C_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_chg_cur_wr,
  input  wire logic        i_chg_volt_wr,
  input  wire logic        i_battery_present_n_pin,
  input  wire logic        i_adapter_present,
  input  wire logic        i_reverse_mode,
  input  wire logic        i_adapter_good_raw,
  input  wire logic        i_hot_alert_lowpower_enable,
  input  wire logic        i_hot_alert_set,
  input  wire logic        i_monitor_buf_set,
  input  wire logic        i_comparator_set,
  output logic             o_charge_current_force_zero,
  output logic             o_input_limit_loop_enable,
  output logic             o_adapter_good_output,
  output cow0_power_s      o_power,
  output cow0_switch_s     o_switch
);

  initial begin
    if (WDT_A_CYC < 1 || WDT_B_CYC < WDT_A_CYC || WDT_C_CYC < WDT_B_CYC ||
        WDT_C_CYC >= 64'h1_0000_0000) begin
      $error("cow0_regbank: watchdog counts out of range");
    end
  end

  logic [15:0] word_q;
  logic [31:0] wdt_cnt_q;
  logic        wdt_expired_q;
  logic        bat_n_q;
  logic        wr_lo;
  logic        wr_hi;
  logic        bat_only;
  logic        lowpwr;
  logic [31:0] wdt_limit;

  assign wr_lo    = i_reg_wr && (i_reg_addr == COW0_OFS_LO);
  assign wr_hi    = i_reg_wr && (i_reg_addr == COW0_OFS_HI);
  assign bat_only = !i_adapter_present && i_battery_present_n_pin;
  assign lowpwr   = word_q[COW0_BIT_LOWPWR] && bat_only;

  always_comb begin
    unique case (word_q[COW0_BIT_WDT_HI:COW0_BIT_WDT_LO])
      COW0_WDT_5S:  wdt_limit = 32'(WDT_A_CYC);
      COW0_WDT_88S: wdt_limit = 32'(WDT_B_CYC);
      default:      wdt_limit = 32'(WDT_C_CYC);
    endcase
  end

  // Word storage; the loop enable is cleared when the pin falls low and auto-off is set.
  always_ff @(posedge i_clk_sys) begin
    bat_n_q <= i_sys_rst ? 1'b0 : i_battery_present_n_pin;
    if (i_sys_rst) begin
      word_q <= COW0_RESET;
    end else begin
      if (wr_hi) begin
        word_q[15:8] <= i_reg_wdata;
      end
      if (wr_lo) begin
        word_q[7:0] <= i_reg_wdata;
      end
      if (word_q[COW0_BIT_AUTOOFF] && !i_battery_present_n_pin && bat_n_q) begin
        word_q[COW0_BIT_LOOPEN] <= 1'b0;
      end
    end
  end

  // Watchdog: restarts on charge writes or a write of the period field.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wdt_cnt_q     <= 32'h0;
      wdt_expired_q <= 1'b0;
    end else if (i_chg_cur_wr || i_chg_volt_wr || wr_hi) begin
      wdt_cnt_q     <= 32'h0;
      wdt_expired_q <= 1'b0;
    end else if (word_q[COW0_BIT_WDT_HI:COW0_BIT_WDT_LO] == COW0_WDT_OFF) begin
      wdt_cnt_q <= 32'h0;
    end else if (!wdt_expired_q) begin
      if (wdt_cnt_q >= wdt_limit - 32'h1) begin
        wdt_expired_q <= 1'b1;
      end else begin
        wdt_cnt_q <= wdt_cnt_q + 32'h1;
      end
    end
  end

  // Register read port.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        COW0_OFS_LO: o_reg_rdata <= word_q[7:0];
        COW0_OFS_HI: o_reg_rdata <= word_q[15:8];
        default:     o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // Outputs to the charger core.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_charge_current_force_zero <= 1'b0;
      o_input_limit_loop_enable   <= 1'b1;
      o_adapter_good_output       <= 1'b0;
      o_power                     <= '0;
      o_switch                    <= '0;
    end else begin
      o_charge_current_force_zero <= wdt_expired_q;
      o_input_limit_loop_enable   <= word_q[COW0_BIT_LOOPEN];
      o_adapter_good_output <= i_adapter_good_raw ||
                               (word_q[COW0_BIT_REVGOOD] && i_reverse_mode);
      o_power.regulator_on   <= !lowpwr;
      o_power.adc_avail      <= !lowpwr;
      o_power.monitor_buf_on <= !lowpwr && i_monitor_buf_set;
      o_power.hot_alert_on   <= lowpwr ? i_hot_alert_lowpower_enable
                                       : i_hot_alert_set;
      o_power.comparator_on  <= lowpwr ? i_hot_alert_lowpower_enable
                                       : i_comparator_set;
      o_switch.rate_800k       <= word_q[COW0_BIT_RATE];
      o_switch.audible_clamp   <= word_q[COW0_BIT_AUDIBLE];
      o_switch.strong_drive_on <= !word_q[COW0_BIT_STRONG];
    end
  end

endmodule // cow0_regbank

// ===== testbench/cow0_regbank_asserts.sv
// Checker for the option word register bank.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module cow0_regbank_asserts
  import cow0_pkg::*;
(
  input wire logic         i_clk_sys, i_sys_rst, i_reg_wr, i_reg_rd, i_chg_cur_wr,
  input wire logic         i_chg_volt_wr, i_battery_present_n_pin, i_adapter_present,
  input wire logic         i_reverse_mode, i_adapter_good_raw, i_hot_alert_set,
  input wire logic         i_hot_alert_lowpower_enable, o_charge_current_force_zero,
  input wire logic         o_adapter_good_output,
  input wire logic [7:0]   i_reg_addr, i_reg_wdata, o_reg_rdata,
  input wire cow0_power_s  o_power,
  input wire cow0_switch_s o_switch
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire hi_wr = i_reg_wr && i_reg_addr == 8'h01;
  property p_raw; i_adapter_good_raw |=> o_adapter_good_output; endproperty
  a_raw: assert property (p_raw) else $error("good lost");
  property p_norev; !i_reverse_mode && !i_adapter_good_raw |=> !o_adapter_good_output;
  endproperty
  a_norev: assert property (p_norev) else $error("good forced");
  property p_perf; i_adapter_present && i_hot_alert_set |=> o_power.hot_alert_on; endproperty
  a_perf: assert property (p_perf) else $error("hot alert off");
  property p_lp; !$past(i_sys_rst) && !o_power.adc_avail
    |-> !$past(i_adapter_present) && $past(i_battery_present_n_pin); endproperty
  a_lp: assert property (p_lp) else $error("low power cause");
  property p_lpcmp; !$past(i_sys_rst) && !o_power.adc_avail
    |-> o_power.comparator_on == $past(i_hot_alert_lowpower_enable); endproperty
  a_lpcmp: assert property (p_lpcmp) else $error("comparator");
  property p_kick; i_chg_cur_wr || i_chg_volt_wr || hi_wr
    |-> ##2 !o_charge_current_force_zero; endproperty
  a_kick: assert property (p_kick) else $error("no restart");
  property p_rdx; i_reg_rd && i_reg_addr > 8'h01 |=> o_reg_rdata == 8'h00; endproperty
  a_rdx: assert property (p_rdx) else $error("unmapped read");
  property p_sw; hi_wr |-> ##2 o_switch == {$past(i_reg_wdata[1], 2),
    $past(i_reg_wdata[2], 2), !$past(i_reg_wdata[0], 2)}; endproperty
  a_sw: assert property (p_sw) else $error("switch bits");
  c_fz: cover property ($rose(o_charge_current_force_zero));
  c_lp: cover property (!o_power.adc_avail);
  c_rev: cover property (o_adapter_good_output && !i_adapter_good_raw);
endmodule // cow0_regbank_asserts
bind cow0_regbank cow0_regbank_asserts i_chk (.*);

// ===== testbench/cow0_host.sv
// Host model driving the byte register port.
// Assumes the bank samples on the rising clock edge.
`timescale 1ns/100ps
module cow0_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic            wr = 1'b0,
  output logic            rd = 1'b0,
  output logic      [7:0] a  = 8'h00,
  output logic      [7:0] d  = 8'h00
);
  task automatic put(input logic [7:0] ad, dd);
    @(negedge clk); a = ad; d = dd; wr = 1'b1;
    @(negedge clk); wr = 1'b0; d = ~dd;
  endtask
  task automatic get(input logic [7:0] ad, output logic [7:0] q);
    @(negedge clk); a = ad; rd = 1'b1;
    @(negedge clk); rd = 1'b0; q = rdata;
  endtask
endmodule // cow0_host

// ===== testbench/charger_option_word_zero_test.sv
// Testbench for the option word register bank.
// Assumes the short watchdog periods of 20, 40 and 80 cycles.
`timescale 1ns/100ps
module charger_option_word_zero_test;
  import cow0_pkg::*;
  logic clk = 0, rst = 1, cur = 0, volt = 0, bat_n = 1, adp = 0, rev = 0, raw = 0, lpe = 0;
  logic set = 1, wr, rd, fz, loop, good;
  logic [7:0] a, d, rdata, q;
  cow0_power_s  pw;
  cow0_switch_s sw;
  int mismatches = 0, checks = 0;
  cow0_host i_cow0_host (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd), .a(a), .d(d));
  cow0_regbank #(.WDT_A_CYC(20), .WDT_B_CYC(40), .WDT_C_CYC(80)) i_cow0_regbank (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(a),
    .i_reg_wdata(d), .o_reg_rdata(rdata), .i_chg_cur_wr(cur), .i_chg_volt_wr(volt),
    .i_battery_present_n_pin(bat_n), .i_adapter_present(adp), .i_reverse_mode(rev),
    .i_adapter_good_raw(raw), .i_hot_alert_lowpower_enable(lpe), .i_hot_alert_set(set),
    .i_monitor_buf_set(set), .i_comparator_set(set), .o_charge_current_force_zero(fz),
    .o_input_limit_loop_enable(loop), .o_adapter_good_output(good), .o_power(pw),
    .o_switch(sw));
  initial forever #25 clk = ~clk;
  task automatic w(int n); repeat (n) @(negedge clk); endtask
  task automatic chk(string s, logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rdchk(logic [7:0] ad, e); i_cow0_host.get(ad, q); chk("rdata", e, q); endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin #100000; mismatches++; wrap_up; end
  initial begin
    w(10); rst = 0; w(3);
    rdchk(8'h00, 8'h0E);
    rdchk(8'h01, 8'hE7);
    rdchk(8'h02, 8'h00);
    chk("sw", 8'h06, {5'h00, sw});
    chk("pw", 8'h00, {3'h0, pw});
    lpe = 1; w(3); chk("pw", 8'h0A, {3'h0, pw});
    adp = 1; i_cow0_host.put(8'h01, 8'h38);
    adp = 0; w(3); chk("pw", 8'h1F, {3'h0, pw});
    chk("sw", 8'h01, {5'h00, sw});
    w(8); chk("fz", 8'h00, {7'h00, fz});
    w(14); chk("fz", 8'h01, {7'h00, fz});
    for (int i = 1; i < 3; i++) begin
      {volt, cur} = 2'(i); w(1); {volt, cur} = 2'b00; w(3);
      chk("fz", 8'h00, {7'h00, fz});
      w(22); chk("fz", 8'h01, {7'h00, fz});
    end
    for (int p = 0; p < 4; p++) begin
      i_cow0_host.put(8'h01, {1'b0, 2'(p), 5'h18}); w(p > 0 ? (10 << p) - 4 : 200);
      chk("fz", 8'h00, {7'h00, fz});
      if (p > 0) begin w(8); chk("fz", 8'h01, {7'h00, fz}); end
    end
    bat_n = 0; w(3); chk("loop", 8'h00, {7'h00, loop});
    i_cow0_host.put(8'h00, 8'h0E); w(2); chk("loop", 8'h01, {7'h00, loop});
    bat_n = 1; i_cow0_host.put(8'h01, 8'h08); w(2);
    bat_n = 0; w(3); chk("loop", 8'h01, {7'h00, loop});
    rev = 1; w(3); chk("good", 8'h01, {7'h00, good});
    i_cow0_host.put(8'h01, 8'h00); w(2); chk("good", 8'h00, {7'h00, good});
    raw = 1; w(2); chk("good", 8'h01, {7'h00, good});
    wrap_up;
  end
endmodule // charger_option_word_zero_test
